// ===== ucr_router.v
// primary uart command router, bypass control and pass-through pin routing
// Notes on behaviour
// - after reset the primary channel is in base mode with register access
// - bypass mode never decodes host bytes as register accesses
// - bypass mode forwards every host byte unchanged over the link
// - bypass can be entered any time without reset, but soft bypass ends only by timeout or reset
// - two pass-through channels carry link data only, no register access
// - primary receive on pin eleven, transmit on pin twelve by default
// - register 0x01 fields detach primary pins and block remote control
// - soft-bypass enable in register 0x48 puts primary channel into bypass
// - timeout field selects 2ms, 8ms, 32ms or no timeout
// - soft bypass ends after selected time without receive line transitions
// - no-timeout setting keeps soft bypass until reset
// - remote mode-select enable lets mode-select level drive bypass directly
// - local mode-select enable takes mode-select from general pin two
// - each pass-through channel works only when its enable bit is set
// - pins 0/1 carry channel one, 5/6 channel two, swapped on request
// - primary uart behaviour applies only when the power-up strap selected uart; pass-through routing ignores the strap
// - bit 6 of 0x03 swaps pass-through channel pin assignments
// - bits 5 and 4 of 0x03 enable channel two and channel one
`timescale 1ns/100ps
`include "ucr_defs.vh"
module ucr_router #(
    parameter [23:0] TO_2MS_CYC  = `UCR_TO_2MS_US  * 1000 / (`UCR_CLK_PERIOD_PS / 1000),
    parameter [23:0] TO_8MS_CYC  = `UCR_TO_8MS_US  * 1000 / (`UCR_CLK_PERIOD_PS / 1000),
    parameter [23:0] TO_32MS_CYC = `UCR_TO_32MS_US * 1000 / (`UCR_CLK_PERIOD_PS / 1000)
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst,
    // power-up strap, high selects i2c
    input  wire       interface_select_strap,
    // host command bytes from the primary receiver
    input  wire [7:0] host_byte,
    input  wire       host_byte_valid,
    output wire       host_byte_ready,
    // read answers toward the primary transmitter
    output reg  [7:0] resp_byte,
    output reg        resp_valid,
    // bytes toward the serial link
    output wire [7:0] link_byte,
    output wire       link_byte_valid,
    input  wire       link_byte_ready,
    // primary transmit line arriving from the link side
    input  wire       primary_tx_line,
    output reg        primary_rx_line,
    // pass-through line levels between link and pins
    input  wire       pass_one_transmit,
    input  wire       pass_two_transmit,
    output reg        pass_one_receive,
    output reg        pass_two_receive,
    // mode-select sources
    input  wire       multifunction_pin_8_in,
    input  wire       general_purpose_pin_2_in,
    // multifunction pins 0, 1, 5, 6, 11, 12
    input  wire       multifunction_pin_0_in,
    output reg        multifunction_pin_0_out,
    output reg        multifunction_pin_0_oe_n,
    input  wire       multifunction_pin_1_in,
    output reg        multifunction_pin_1_out,
    output reg        multifunction_pin_1_oe_n,
    input  wire       multifunction_pin_5_in,
    output reg        multifunction_pin_5_out,
    output reg        multifunction_pin_5_oe_n,
    input  wire       multifunction_pin_6_in,
    output reg        multifunction_pin_6_out,
    output reg        multifunction_pin_6_oe_n,
    input  wire       multifunction_pin_11_in,
    output reg        multifunction_pin_11_out,
    output reg        multifunction_pin_11_oe_n,
    input  wire       multifunction_pin_12_in,
    output reg        multifunction_pin_12_out,
    output reg        multifunction_pin_12_oe_n,
    // state seen by the system
    output wire       bypass_active,
    output wire       uart_selected
);
    // command states, one-hot
    localparam [2:0] ST_CMD  = 3'h1;
    localparam [2:0] ST_ADDR = 3'h2;
    localparam [2:0] ST_DATA = 3'h4;

    reg  [7:0]  control_channel_access;
    reg  [7:0]  pass_through_uart_enable;
    reg  [7:0]  uart_bypass_control;
    reg         soft_bypass;
    reg  [23:0] idle_count;
    reg         interface_select_latch;
    reg         strap_taken;
    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg         cmd_remote;
    reg         cmd_write;
    reg  [7:0]  cmd_addr;
    reg         rx_prev;
    reg  [23:0] to_limit;
    reg  [7:0]  rd_value;
    wire        local_line_disable;
    wire        remote_access_disable;
    wire        pass_through_swap;
    wire        pt_one_en;
    wire        pt_two_en;
    wire [1:0]  bypass_timeout_select;
    wire        remote_mode_select_enable;
    wire        local_mode_select_enable;
    wire        mode_select_input;
    wire        rx_level;
    wire        rx_edge;
    wire        forward_byte;
    wire        take_byte;
    wire        local_take;
    wire        reg_write;
    wire        fifo_in_ready;

    // field views
    assign local_line_disable        = control_channel_access[`UCR_LOCAL_LINE_DIS_BIT];
    assign remote_access_disable     = control_channel_access[`UCR_REMOTE_ACC_DIS_BIT];
    assign pass_through_swap         = pass_through_uart_enable[`UCR_PT_SWAP_BIT];
    assign pt_one_en                 = pass_through_uart_enable[`UCR_PT_ONE_EN_BIT];
    assign pt_two_en                 = pass_through_uart_enable[`UCR_PT_TWO_EN_BIT];
    assign bypass_timeout_select     = uart_bypass_control[`UCR_BYP_TO_MSB:`UCR_BYP_TO_LSB];
    assign remote_mode_select_enable = uart_bypass_control[`UCR_REMOTE_MODE_SELECT_ENABLE_BIT];
    assign local_mode_select_enable  = uart_bypass_control[`UCR_LOCAL_MODE_SELECT_ENABLE_BIT];

    // strap caught on first edge after reset release
    always @(posedge clk) begin
        if (rst) begin
            strap_taken            <= 1'b0;
            interface_select_latch <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken            <= 1'b1;
            interface_select_latch <= interface_select_strap;
        end
    end
    assign uart_selected = strap_taken & ~interface_select_latch;

    // mode-select source and combined bypass
    assign mode_select_input = local_mode_select_enable ? general_purpose_pin_2_in
                                                        : multifunction_pin_8_in;
    assign bypass_active = soft_bypass
                         | (remote_mode_select_enable & mode_select_input);

    // receive line activity, idle high when detached
    assign rx_level = local_line_disable ? 1'b1 : multifunction_pin_11_in;
    assign rx_edge  = rx_level ^ rx_prev;

    // selected inactivity limit
    always @* begin
        case (bypass_timeout_select)
            `UCR_TO_2MS:  to_limit = TO_2MS_CYC;
            `UCR_TO_8MS:  to_limit = TO_8MS_CYC;
            `UCR_TO_32MS: to_limit = TO_32MS_CYC;
            default:      to_limit = 24'hFFFFFF;
        endcase
    end

    // byte handling: forward or decode
    assign forward_byte = bypass_active
                        | (state == ST_CMD ? host_byte[`UCR_CMD_REMOTE_BIT] : cmd_remote);
    assign host_byte_ready = (forward_byte ? fifo_in_ready : 1'b1) & uart_selected;
    assign take_byte  = host_byte_valid & host_byte_ready;
    assign local_take = take_byte & ~bypass_active;
    assign reg_write  = local_take & (state == ST_DATA) & ~cmd_remote;

    // command sequencing
    always @* begin
        next_state = state;
        case (state)
            ST_CMD:  if (local_take) next_state = ST_ADDR;
            ST_ADDR: if (local_take) next_state = cmd_write ? ST_DATA : ST_CMD;
            ST_DATA: if (local_take) next_state = ST_CMD;
            default: next_state = ST_CMD;
        endcase
        if (bypass_active)
            next_state = ST_CMD;
    end

    always @(posedge clk) begin
        if (rst) begin
            state      <= ST_CMD;
            cmd_remote <= 1'b0;
            cmd_write  <= 1'b0;
            cmd_addr   <= 8'h00;
        end else begin
            state <= next_state;
            if (local_take && state == ST_CMD) begin
                cmd_remote <= host_byte[`UCR_CMD_REMOTE_BIT];
                cmd_write  <= host_byte[`UCR_CMD_WRITE_BIT];
            end
            if (local_take && state == ST_ADDR)
                cmd_addr <= host_byte;
        end
    end

    // register writes
    always @(posedge clk) begin
        if (rst) begin
            control_channel_access   <= `UCR_RST_CC_ACCESS;
            pass_through_uart_enable <= `UCR_RST_PT_ENABLE;
            uart_bypass_control      <= `UCR_RST_BYPASS_CTRL;
        end else if (reg_write) begin
            case (cmd_addr)
                `UCR_REG_CC_ACCESS:   control_channel_access   <= host_byte;
                `UCR_REG_PT_ENABLE:   pass_through_uart_enable <= host_byte;
                `UCR_REG_BYPASS_CTRL: uart_bypass_control      <= host_byte;
                default:              control_channel_access   <= control_channel_access;
            endcase
        end
    end

    // soft bypass with inactivity timeout, a write setting it wins
    always @(posedge clk) begin
        if (rst) begin
            soft_bypass <= 1'b0;
            idle_count  <= 24'h000000;
            rx_prev     <= 1'b1;
        end else begin
            rx_prev <= rx_level;
            if (reg_write && cmd_addr == `UCR_REG_BYPASS_CTRL) begin
                soft_bypass <= host_byte[`UCR_BYP_EN_BIT];
                idle_count  <= 24'h000000;
            end else if (!soft_bypass || rx_edge) begin
                idle_count  <= 24'h000000;
            end else if (bypass_timeout_select == `UCR_TO_NONE) begin
                idle_count  <= 24'h000000;
            end else if (idle_count >= to_limit - 24'h000001) begin
                soft_bypass <= 1'b0;
                idle_count  <= 24'h000000;
            end else begin
                idle_count  <= idle_count + 24'h000001;
            end
        end
    end

    // read data, bypass enable reads the live soft state
    always @* begin
        case (cmd_addr)
            `UCR_REG_CC_ACCESS:   rd_value = control_channel_access;
            `UCR_REG_PT_ENABLE:   rd_value = pass_through_uart_enable;
            `UCR_REG_BYPASS_CTRL: rd_value = {uart_bypass_control[7:1], soft_bypass};
            default:              rd_value = 8'h00;
        endcase
    end

    // read answers
    always @(posedge clk) begin
        if (rst) begin
            resp_byte  <= 8'h00;
            resp_valid <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
            if (local_take && state == ST_ADDR && !cmd_write && !cmd_remote) begin
                resp_byte  <= (host_byte == cmd_addr) ? rd_value : 8'h00;
                resp_valid <= 1'b1;
            end
            if (local_take && state == ST_ADDR && !cmd_write && !cmd_remote) begin
                case (host_byte)
                    `UCR_REG_CC_ACCESS:   resp_byte <= control_channel_access;
                    `UCR_REG_PT_ENABLE:   resp_byte <= pass_through_uart_enable;
                    `UCR_REG_BYPASS_CTRL: resp_byte <= {uart_bypass_control[7:1], soft_bypass};
                    default:              resp_byte <= 8'h00;
                endcase
            end
        end
    end

    // pin and line routing, registered
    always @(posedge clk) begin
        if (rst) begin
            primary_rx_line           <= 1'b1;
            pass_one_receive          <= 1'b1;
            pass_two_receive          <= 1'b1;
            multifunction_pin_0_out   <= 1'b1;
            multifunction_pin_0_oe_n  <= 1'b1;
            multifunction_pin_1_out   <= 1'b1;
            multifunction_pin_1_oe_n  <= 1'b1;
            multifunction_pin_5_out   <= 1'b1;
            multifunction_pin_5_oe_n  <= 1'b1;
            multifunction_pin_6_out   <= 1'b1;
            multifunction_pin_6_oe_n  <= 1'b1;
            multifunction_pin_11_out  <= 1'b1;
            multifunction_pin_11_oe_n <= 1'b1;
            multifunction_pin_12_out  <= 1'b1;
            multifunction_pin_12_oe_n <= 1'b1;
        end else begin
            // primary channel: receive on 11, transmit on 12
            primary_rx_line           <= uart_selected ? rx_level : 1'b1;
            multifunction_pin_11_out  <= 1'b1;
            multifunction_pin_11_oe_n <= 1'b1;
            multifunction_pin_12_out  <= primary_tx_line;
            multifunction_pin_12_oe_n <= ~uart_selected | local_line_disable;
            // channel one receive: pins 0 normally, 5 when swapped
            if (pt_one_en)
                pass_one_receive <= pass_through_swap ? multifunction_pin_5_in
                                                      : multifunction_pin_0_in;
            else
                pass_one_receive <= 1'b1;
            if (pt_two_en)
                pass_two_receive <= pass_through_swap ? multifunction_pin_0_in
                                                      : multifunction_pin_5_in;
            else
                pass_two_receive <= 1'b1;
            // transmit pins 1 and 6
            multifunction_pin_0_out  <= 1'b1;
            multifunction_pin_0_oe_n <= 1'b1;
            multifunction_pin_5_out  <= 1'b1;
            multifunction_pin_5_oe_n <= 1'b1;
            multifunction_pin_1_out  <= pass_through_swap ? pass_two_transmit
                                                          : pass_one_transmit;
            multifunction_pin_1_oe_n <= pass_through_swap ? ~pt_two_en : ~pt_one_en;
            multifunction_pin_6_out  <= pass_through_swap ? pass_one_transmit
                                                          : pass_two_transmit;
            multifunction_pin_6_oe_n <= pass_through_swap ? ~pt_one_en : ~pt_two_en;
        end
    end

    // link fifo: forwarded bytes, remote commands dropped if blocked
    ucr_fifo #(
        .WIDTH (`UCR_FIFO_WIDTH),
        .DEPTH (`UCR_FIFO_DEPTH),
        .AW    (`UCR_FIFO_AW)
    ) u_link_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_data   (host_byte),
        .in_valid  (host_byte_valid & uart_selected & forward_byte
                    & (bypass_active | ~remote_access_disable)),
        .in_ready  (fifo_in_ready),
        .out_data  (link_byte),
        .out_valid (link_byte_valid),
        .out_ready (link_byte_ready)
    );
endmodule // ucr_router

// ===== ucr_defs.vh
// constants for the uart control channel mode router
`ifndef UCR_DEFS_VH
`define UCR_DEFS_VH

// register offsets
`define UCR_REG_CC_ACCESS      8'h01
`define UCR_REG_PT_ENABLE      8'h03
`define UCR_REG_BYPASS_CTRL    8'h48

// reset values
`define UCR_RST_CC_ACCESS      8'h00
`define UCR_RST_PT_ENABLE      8'h05
`define UCR_RST_BYPASS_CTRL    8'h00

// control_channel_access fields
`define UCR_LOCAL_LINE_DIS_BIT 5
`define UCR_REMOTE_ACC_DIS_BIT 4

// pass_through_uart_enable fields
`define UCR_PT_SWAP_BIT        6
`define UCR_PT_TWO_EN_BIT      5
`define UCR_PT_ONE_EN_BIT      4

// uart_bypass_control fields
`define UCR_BYP_EN_BIT         0
`define UCR_BYP_TO_LSB         1
`define UCR_BYP_TO_MSB         2
`define UCR_REMOTE_MODE_SELECT_ENABLE_BIT      3
`define UCR_LOCAL_MODE_SELECT_ENABLE_BIT      4

// timeout select codes
`define UCR_TO_2MS             2'h0
`define UCR_TO_8MS             2'h1
`define UCR_TO_32MS            2'h2
`define UCR_TO_NONE            2'h3

// command byte fields
`define UCR_CMD_REMOTE_BIT     7
`define UCR_CMD_WRITE_BIT      0

// timing
`define UCR_CLK_PERIOD_PS      5000
`define UCR_TO_2MS_US          2000
`define UCR_TO_8MS_US          8000
`define UCR_TO_32MS_US         32000

// fifo
`define UCR_FIFO_WIDTH         8
`define UCR_FIFO_DEPTH         32
`define UCR_FIFO_AW            5

`endif

// ===== ucr_fifo.v
// byte fifo between command router and serial link
`timescale 1ns/100ps
module ucr_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst,
    // fill side
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    // drain side
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    // honest full and empty
    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // pointers and occupancy
    always @(posedge clk) begin
        if (rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            if (pop)
                rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
            if (push & ~pop)
                count <= count + {{AW{1'b0}}, 1'b1};
            else if (pop & ~push)
                count <= count - {{AW{1'b0}}, 1'b1};
        end
    end

    // storage
    always @(posedge clk) begin
        if (push)
            mem[wr_ptr] <= in_data;
    end
endmodule // ucr_fifo

// ===== ucr_chk.sv
// assertion checker for the uart mode router ports
`timescale 1ns/100ps
module ucr_chk (
    // clock and reset
    input wire       clk,
    input wire       rst,
    // host side
    input wire       uart_selected,
    input wire       host_byte_ready,
    input wire       resp_valid,
    input wire [7:0] resp_byte,
    // link side
    input wire [7:0] link_byte,
    input wire       link_byte_valid,
    input wire       link_byte_ready,
    input wire       primary_tx_line,
    input wire       primary_rx_line,
    input wire       pass_one_receive,
    input wire       pass_two_receive,
    // pins
    input wire       multifunction_pin_0_in,
    input wire       multifunction_pin_5_in,
    input wire       multifunction_pin_11_in,
    input wire       multifunction_pin_12_out,
    input wire       multifunction_pin_12_oe_n,
    input wire       bypass_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // answers, strap and stream handshake
    a_resp_one_cycle: assert property (resp_valid |=> !resp_valid)
        else $error("resp_valid held too long");
    a_resp_byte_held: assert property (!resp_valid |-> $stable(resp_byte))
        else $error("resp_byte moved without resp_valid");
    a_strap_no_ready: assert property (!uart_selected |-> !host_byte_ready)
        else $error("host byte taken without uart selected");
    a_rx_idle_high: assert property ($past(!uart_selected) && !uart_selected |-> primary_rx_line)
        else $error("primary rx not idle while not uart");
    a_link_hold: assert property (link_byte_valid && !link_byte_ready
        |=> link_byte_valid && $stable(link_byte))
        else $error("link byte dropped during stall");
    // pin routing
    a_rx_from_pin: assert property (!primary_rx_line |-> !$past(multifunction_pin_11_in))
        else $error("primary rx low without pin eleven low");
    a_tx_to_pin: assert property (!multifunction_pin_12_oe_n
        |-> multifunction_pin_12_out == $past(primary_tx_line))
        else $error("pin twelve not following primary tx");
    a_one_source: assert property (!pass_one_receive
        |-> !$past(multifunction_pin_0_in) || !$past(multifunction_pin_5_in))
        else $error("pass one receive low without its pin");
    a_two_source: assert property (!pass_two_receive
        |-> !$past(multifunction_pin_0_in) || !$past(multifunction_pin_5_in))
        else $error("pass two receive low without its pin");
    // main scenarios
    c_bypass: cover property ($rose(bypass_active));
    c_bypass_end: cover property ($fell(bypass_active));
    c_read: cover property (resp_valid);
    c_stall: cover property (link_byte_valid && !link_byte_ready);
endmodule // ucr_chk
bind ucr_router ucr_chk chk_u (.*);

// ===== ucr_link_model.sv
// far side of the serial link: byte sink with stalls and line sources
`timescale 1ns/100ps
module ucr_link (
    // clock
    input  wire       clk,
    // byte stream from the router
    input  wire [7:0] link_byte,
    input  wire       link_byte_valid,
    output reg        link_byte_ready,
    // line levels toward the pins
    output reg        primary_tx_line,
    output reg        pass_one_transmit,
    output reg        pass_two_transmit
);
    logic [7:0] got [$];
    bit         stall = 1'b0;
    initial link_byte_ready = 1'b0;
    initial {primary_tx_line, pass_one_transmit, pass_two_transmit} = 3'h7;
    // collect bytes, stall at random, lines take new random levels every cycle
    always @(posedge clk) begin
        if (link_byte_valid && link_byte_ready) got.push_back(link_byte);
        link_byte_ready <= !stall && ($urandom_range(3) != 0);
        {primary_tx_line, pass_one_transmit, pass_two_transmit} <= $urandom;
    end
endmodule // ucr_link

// ===== tb_top.sv
// self-checking bench for the uart mode router
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module tb_top;
    logic       clk = 1'b0, rst = 1'b1, hv = 1'b0, p8 = 1'b0, g2 = 1'b0, p11 = 1'b1;
    logic [7:0] hb = 8'h00, v, a0;
    logic [4:0] pr = 5'h1F;
    logic [3:0] smp;
    wire  [7:0] rb, lb;
    wire  [5:0] po, poe;
    wire        hr, rv, lv, lr, ptx, prx, t1, t2, r1, r2, byp, usel;
    int         err_total = 0, n_compared = 0, n_resp = 0, i, k, nr;
    logic [7:0] exq [$];
    bit   [2:0] ms [5] = '{3'b101, 3'b000, 3'b100, 3'b011, 3'b000};
    always #2.5 clk = ~clk;
    // random levels on pins 0, 1, 5, 6, 12
    always @(posedge clk) pr <= $urandom;
    always @(posedge clk) if (rv === 1'b1) n_resp++;
    ucr_router #(.TO_2MS_CYC(24'd20), .TO_8MS_CYC(24'd40), .TO_32MS_CYC(24'd80)) dut_u (
        .clk(clk), .rst(rst), .interface_select_strap(1'b0),
        .host_byte(hb), .host_byte_valid(hv), .host_byte_ready(hr),
        .resp_byte(rb), .resp_valid(rv),
        .link_byte(lb), .link_byte_valid(lv), .link_byte_ready(lr),
        .primary_tx_line(ptx), .primary_rx_line(prx),
        .pass_one_transmit(t1), .pass_two_transmit(t2),
        .pass_one_receive(r1), .pass_two_receive(r2),
        .multifunction_pin_8_in(p8), .general_purpose_pin_2_in(g2),
        .multifunction_pin_0_in(pr[0]), .multifunction_pin_0_out(po[0]),
        .multifunction_pin_0_oe_n(poe[0]), .multifunction_pin_1_in(pr[1]),
        .multifunction_pin_1_out(po[1]), .multifunction_pin_1_oe_n(poe[1]),
        .multifunction_pin_5_in(pr[2]), .multifunction_pin_5_out(po[2]),
        .multifunction_pin_5_oe_n(poe[2]), .multifunction_pin_6_in(pr[3]),
        .multifunction_pin_6_out(po[3]), .multifunction_pin_6_oe_n(poe[3]),
        .multifunction_pin_11_in(p11), .multifunction_pin_11_out(po[4]),
        .multifunction_pin_11_oe_n(poe[4]), .multifunction_pin_12_in(pr[4]),
        .multifunction_pin_12_out(po[5]), .multifunction_pin_12_oe_n(poe[5]),
        .bypass_active(byp), .uart_selected(usel)
    );
    ucr_link lnk_u (.clk(clk), .link_byte(lb), .link_byte_valid(lv), .link_byte_ready(lr),
        .primary_tx_line(ptx), .pass_one_transmit(t1), .pass_two_transmit(t2));
    // end of run
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // offer one byte from a clock edge and hold it until taken
    task automatic send(input logic [7:0] b);
        hb <= b;
        hv <= 1'b1;
        for (int j = 0; j < 300; j++) begin
            #1;
            if (hr === 1'b1) begin
                @(posedge clk);
                return;
            end
            @(posedge clk);
        end
        $display("MISMATCH host_byte_ready exp 1 got timeout");
        err_total++;
        print_verdict();
    endtask
    // local register write, with settle time after channel changes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        send(8'h01);
        send(a);
        send(d);
        hv <= 1'b0;
        if (a != 8'h48) repeat (2000) @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        send(8'h00);
        send(a);
        hv <= 1'b0;
        #1;
        for (int j = 0; j < 6 && rv !== 1'b1; j++) @(posedge clk) #1;
        `CHK("resp_valid", 1'b1, rv)
        d = rb;
    endtask
    task automatic wait_chk(input int n, input logic e);
        repeat (n) @(posedge clk);
        #1;
        `CHK("bypass_active", e, byp)
    endtask
    initial begin
        void'($urandom(74926));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (k = 0; k < 10 && usel !== 1'b1; k++) @(posedge clk) #1;
        `CHK("uart_selected", 1'b1, usel)
        // reset values, unmapped read, base mode
        rd(8'h01, v); `CHK("reg01", 8'h00, v)
        rd(8'h03, v); `CHK("reg03", 8'h05, v)
        rd(8'h48, v); `CHK("reg48", 8'h00, v)
        rd(8'h22, v); `CHK("unmapped", 8'h00, v)
        // primary receive from pin eleven, then detached
        @(posedge clk) p11 <= 1'b0;
        wait_chk(2, 1'b0);
        `CHK("primary_rx", 1'b0, prx)
        wr(8'h01, 8'h20);
        #1 `CHK("primary_rx detached", 1'b1, prx)
        wr(8'h01, 8'h10);
        // remote command dropped while remote access is off
        @(posedge clk) send(8'h81); send(8'h11); send(8'h22); hv <= 1'b0;
        wr(8'h01, 8'h00);
        @(posedge clk) send(8'h81); send(8'h10); send(8'h5A); hv <= 1'b0;
        exq = '{8'h81, 8'h10, 8'h5A};
        // pass-through enables and swap
        foreach (ms[k]) begin
            v = (k == 0) ? 8'h10 : (k == 1) ? 8'h30 : (k == 2) ? 8'h70 : 8'h00;
            wr(8'h03, v);
            repeat (4) begin
                @(posedge clk) #1;
                smp = {pr[0], pr[2], t1, t2};
                @(posedge clk) #1;
                `CHK("pass_one_rx", v[4] ? (v[6] ? smp[2] : smp[3]) : 1'b1, r1)
                `CHK("pass_two_rx", v[5] ? (v[6] ? smp[3] : smp[2]) : 1'b1, r2)
                if (v[4] && !v[6] || v[5] && v[6])
                    `CHK("pin1_out", v[6] ? smp[0] : smp[1], po[1])
                `CHK("pin1_oe_n", v[6] ? !v[5] : !v[4], poe[1])
                `CHK("pin6_oe_n", v[6] ? !v[4] : !v[5], poe[3])
            end
        end
        // soft bypass with each timeout, kept alive by line edges in the 2ms case
        for (i = 0; i < 3; i++) begin
            wr(8'h48, 8'h01 | (i << 1));
            if (i == 0) repeat (6) begin
                repeat (5) @(posedge clk);
                p11 <= !p11;
            end
            wait_chk((20 << i) - 6, 1'b1);
            wait_chk(14, 1'b0);
            rd(8'h48, v); `CHK("reg48 after timeout", i << 1, v)
        end
        // mode-select input from pin eight, then from general pin two
        for (i = 0; i < 5; i++) begin
            if (i == 0) wr(8'h48, 8'h08);
            if (i == 2) wr(8'h48, 8'h18);
            @(posedge clk);
            p8 <= ms[i][2];
            g2 <= ms[i][1];
            wait_chk(3, ms[i][0]);
        end
        // bypass without timeout: no decode, bytes forwarded, fifo full
        wr(8'h48, 8'h07);
        nr = n_resp;
        @(posedge clk) lnk_u.stall <= 1'b1;
        for (i = 0; i < 32; i++) begin
            a0 = (i == 0) ? 8'h00 : (i == 1) ? 8'h03 : $urandom;
            send(a0);
            exq.push_back(a0);
        end
        hb <= 8'hC3;
        repeat (3) @(posedge clk);
        #1 `CHK("host_byte_ready full", 1'b0, hr)
        lnk_u.stall = 1'b0;
        @(posedge clk) send(8'hC3);
        exq.push_back(8'hC3);
        hv <= 1'b0;
        for (k = 0; k < 500 && lnk_u.got.size() < exq.size(); k++) @(posedge clk);
        `CHK("link count", exq.size(), lnk_u.got.size())
        foreach (exq[k]) `CHK("link byte", exq[k], lnk_u.got[k])
        `CHK("no answer in bypass", nr, n_resp)
        wait_chk(300, 1'b1);
        print_verdict();
    end
endmodule // tb_top
